// ---- rtl/dcr_pkg.sv ----
package dcr_pkg;

  localparam int NUM_CH = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register map: channel c register r at byte address c*0x20 + r*4
  localparam int CH_LSB = 5;
  localparam logic [2:0] RG_CTRL = 3'h0;
  localparam logic [2:0] RG_REQ = 3'h1;
  localparam logic [2:0] RG_STA = 3'h2;
  localparam logic [2:0] RG_STB = 3'h3;
  localparam logic [2:0] RG_PAD = 3'h4;
  localparam logic [2:0] RG_CNT = 3'h5;
  localparam logic [11:0] STATUS_ADDR = 12'h100;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int B_ON = 15;
  localparam int B_BYTE = 14;
  localparam int B_DIR = 13;
  localparam int B_HALF = 12;
  localparam int B_NULL_PERIPH_WRITE = 11;
  localparam int AM_HI = 5;
  localparam int AM_LO = 4;
  localparam int MB_PP = 1;
  localparam int MB_ONESHOT = 0;
  localparam int B_FORCE = 15;
  localparam int CNT_W = 10;

  // implemented bits of the control register
  localparam logic [15:0] CTRL_MASK = 16'hF833;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // ram addressing codes
  localparam logic [1:0] AM_POSTINC = 2'h0;
  localparam logic [1:0] AM_NOINC = 2'h1;
  localparam logic [1:0] AM_PIND = 2'h2;

  // byte enables
  localparam logic [1:0] BE_LO = 2'h1;
  localparam logic [1:0] BE_HI = 2'h2;
  localparam logic [1:0] BE_WORD = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_READ = 2'h1,
    ST_CAPT = 2'h3,
    ST_WRITE = 2'h2
  } dcr_fsm_type;

endpackage

// ---- rtl/dcr_arb.sv ----
`timescale 1ns/1ps
module dcr_arb import dcr_pkg::*; (
  input wire logic [NUM_CH-1:0] req,
  output logic gnt_valid,
  output logic [2:0] gnt_idx
);

  // fixed priority, lowest channel wins; simple, but a busy low channel
  // can starve the higher ones
  always_comb begin
    gnt_valid = 1'b0;
    gnt_idx = 3'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (req[i]) begin
        gnt_valid = 1'b1;
        gnt_idx = 3'(i);
      end
    end
  end

endmodule

// ---- rtl/dcr_chan.sv ----
`timescale 1ns/1ps
module dcr_chan import dcr_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [5:0] reg_we,
  input wire logic [15:0] wdata,
  input wire logic trig,
  input wire logic step,
  output logic [15:0] ctrl_q,
  output logic [15:0] req_q,
  output logic [15:0] sta_q,
  output logic [15:0] stb_q,
  output logic [15:0] pad_q,
  output logic [15:0] cnt_q,
  output logic [15:0] ram_ptr,
  output logic busy,
  output logic blk_evt
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic force_x;
    logic [6:0] line;
    logic [15:0] primary_start_addr;
    logic [15:0] stb;
    logic [15:0] pad;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] idx;
    logic [15:0] ofs;
    logic pp;
    logic pend;
  } dcr_chan_state_type;

  dcr_chan_state_type s;
  dcr_chan_state_type n;
  logic last;
  logic ppm;
  logic [15:0] base;

  always_comb begin
    n = s;
    // RULE_16 count plus one
    last = (s.idx == s.cnt);
    // RULE_08 ping-pong mode bit
    ppm = s.ctrl[MB_PP];
    if (step) begin
      n.pend = 1'b0;
      // RULE_10 hardware clears force
      n.force_x = 1'b0;
      if (last) begin
        n.idx = 10'h000;
        n.ofs = 16'h0000;
        // RULE_20 swap buffers
        if (ppm) begin
          n.pp = ~s.pp;
        end
        // RULE_21 one-shot stops
        if (s.ctrl[MB_ONESHOT] && (!ppm || s.pp)) begin
          n.ctrl[B_ON] = 1'b0;
        end
      end else begin
        n.idx = s.idx + 10'h001;
        // RULE_22 post-increment step
        n.ofs = s.ofs + (s.ctrl[B_BYTE] ? 16'h0001 : 16'h0002);
      end
    end
    // RULE_09 request line starts a transfer
    if (trig && s.ctrl[B_ON]) begin
      n.pend = 1'b1;
    end
    if (reg_we[RG_CTRL]) begin
      n.ctrl = wdata & CTRL_MASK;
      if (wdata[B_ON] && !s.ctrl[B_ON]) begin
        n.idx = 10'h000;
        n.ofs = 16'h0000;
        n.pp = 1'b0;
        n.pend = 1'b0;
      end
    end
    if (reg_we[RG_REQ]) begin
      // RULE_10 zero does not clear
      if (wdata[B_FORCE]) begin
        n.force_x = 1'b1;
      end
      n.line = wdata[6:0];
    end
    // RULE_12 primary start
    if (reg_we[RG_STA]) begin
      n.primary_start_addr = wdata;
    end
    // RULE_13 secondary start
    if (reg_we[RG_STB]) begin
      n.stb = wdata;
    end
    if (reg_we[RG_PAD]) begin
      n.pad = wdata;
    end
    if (reg_we[RG_CNT]) begin
      n.cnt = wdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // RULE_20 buffer select
  assign base = s.pp ? s.stb : s.primary_start_addr;
  // RULE_07 only post-increment mode adds the running offset
  assign ram_ptr = (s.ctrl[AM_HI:AM_LO] == AM_POSTINC) ? base + s.ofs : base;
  // RULE_02 disabled channel never asks
  assign busy = s.ctrl[B_ON] && (s.pend || s.force_x);
  // RULE_05 half or full block event
  assign blk_evt = step && (s.ctrl[B_HALF] ? (s.idx == {1'b0, s.cnt[CNT_W-1:1]}) : last);
  // RULE_18 unused bits read zero
  assign ctrl_q = s.ctrl;
  assign req_q = {s.force_x, 8'h00, s.line};
  assign sta_q = s.primary_start_addr;
  assign stb_q = s.stb;
  assign pad_q = s.pad;
  assign cnt_q = {6'h00, s.cnt};

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_force_keep;
    s.force_x && !step |=> s.force_x;
  endproperty
  a_force_keep: assert property (p_force_keep) else $error("force lost"); // RULE_10

  property p_count;
    step && !last && !reg_we[RG_CTRL] |=> s.idx == $past(s.idx) + 10'h001;
  endproperty
  a_count: assert property (p_count) else $error("count not advanced"); // RULE_16

  property p_pp_swap;
    step && last && ppm && !reg_we[RG_CTRL] |=> s.pp != $past(s.pp);
  endproperty
  a_pp_swap: assert property (p_pp_swap) else $error("buffer not swapped"); // RULE_20

  property p_oneshot;
    step && last && s.ctrl[MB_ONESHOT] && !ppm && !reg_we[RG_CTRL] |=> !s.ctrl[B_ON];
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot kept running"); // RULE_21

endmodule

// ---- rtl/dcr_dma.sv ----
`timescale 1ns/1ps
// Contract
// RULE_01: eight channels, each with control, select, two starts, address, count.
// RULE_02: control bit 15 enables the channel; disabled channels never transfer.
// RULE_03: control bit 14 set moves a byte, clear moves a 16-bit word.
// RULE_04: control bit 13 set copies ram to peripheral, clear the reverse.
// RULE_05: control bit 12 picks block event at half or at end of block.
// RULE_06: bit 11 with direction clear adds a zero write to the peripheral.
// RULE_07: bits 5-4 pick post-increment, fixed, or peripheral-indexed ram addressing.
// RULE_08: bits 1-0 pick one-shot or continuous, with or without ping-pong.
// RULE_09: force bit gives one transfer; otherwise the selected request line triggers.
// RULE_10: writing zero never clears force; hardware clears it after the transfer.
// RULE_11: select bits 6-0 choose one of 128 request lines.
// RULE_12: sixteen-bit primary ram start address register.
// RULE_13: sixteen-bit secondary ram start address register.
// RULE_14: sixteen-bit peripheral address register used on each transfer.
// RULE_15: software leaves peripheral address and count alone while enabled.
// RULE_16: count field of ten bits; transfers per block equal count plus one.
// RULE_17: shared status word: one clear-only flag per channel in each byte.
// RULE_18: unimplemented bits read zero and ignore writes.
// RULE_19: upper byte flags peripheral write clash, lower byte ram write clash.
// RULE_20: ping-pong alternates primary and secondary start on successive blocks.
// RULE_21: continuous reloads start each block; one-shot stops after its block.
// RULE_22: post-increment advances the ram address by one or two bytes.
module dcr_dma import dcr_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [127:0] irq_lines,
  input wire logic [15:0] periph_index,
  output logic [15:0] ram_addr,
  output logic [15:0] ram_wdata,
  output logic ram_rd,
  output logic ram_wr,
  output logic [1:0] ram_be,
  input wire logic [15:0] ram_rdata,
  output logic [15:0] per_addr,
  output logic [15:0] per_wdata,
  output logic per_rd,
  output logic per_wr,
  output logic [1:0] per_be,
  input wire logic [15:0] per_rdata,
  input wire logic cpu_ram_wr,
  input wire logic [15:0] cpu_ram_addr,
  input wire logic cpu_per_wr,
  input wire logic [15:0] cpu_per_addr,
  output logic [7:0] block_irq
);

  typedef struct packed {
    dcr_fsm_type fsm;
    logic [2:0] ch;
    logic dir;
    logic byte_x;
    logic null_periph_write;
    logic dp_act;
    logic dp_wr;
    logic dp_ok;
    logic dp_word;
    logic rdy;
    logic [11:0] dp_addr;
    logic [31:0] hrdata;
    logic [15:0] status;
    logic [15:0] ram_addr;
    logic [15:0] ram_wdata;
    logic [15:0] per_addr;
    logic [15:0] per_wdata;
    logic ram_rd;
    logic ram_wr;
    logic per_rd;
    logic per_wr;
    logic [1:0] ram_be;
    logic [1:0] per_be;
    logic [7:0] irq;
  } dcr_main_state_type;

  dcr_main_state_type s;
  dcr_main_state_type n;

  logic [15:0] ch_ctrl [0:NUM_CH-1];
  logic [15:0] ch_req [0:NUM_CH-1];
  logic [15:0] ch_sta [0:NUM_CH-1];
  logic [15:0] ch_stb [0:NUM_CH-1];
  logic [15:0] ch_pad [0:NUM_CH-1];
  logic [15:0] ch_cnt [0:NUM_CH-1];
  logic [15:0] ch_ptr [0:NUM_CH-1];
  logic [NUM_CH-1:0] ch_busy;
  logic [NUM_CH-1:0] ch_evt;
  logic [NUM_CH-1:0] trig;
  logic [NUM_CH-1:0] step;
  logic [NUM_CH-1:0] set_p;
  logic [NUM_CH-1:0] set_x;
  logic gv;
  logic [2:0] gi;
  logic [2:0] dsel_ch;
  logic [2:0] dsel_rg;
  logic chan_hit;
  logic stat_hit;
  logic wr_chan;
  logic wr_stat;
  logic [5:0] reg_we1h;
  logic [15:0] rdv;
  logic [15:0] src;
  logic [7:0] bval;
  logic [15:0] wd;
  logic [15:0] ctl;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode of the data phase
  assign dsel_ch = s.dp_addr[CH_LSB+2:CH_LSB];
  assign dsel_rg = s.dp_addr[CH_LSB-1:2];
  assign chan_hit = s.dp_ok && (s.dp_addr[11:8] == 4'h0) && (dsel_rg <= RG_CNT);
  assign stat_hit = s.dp_ok && (s.dp_addr == STATUS_ADDR);
  // sub-word writes are ignored; only whole words reach the registers
  assign wr_chan = s.dp_act && s.dp_wr && s.dp_word && chan_hit;
  assign wr_stat = s.dp_act && s.dp_wr && s.dp_word && stat_hit;
  assign reg_we1h = 6'h01 << dsel_rg;
  assign step = (s.fsm == ST_WRITE) ? (8'h01 << s.ch) : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // channels
  // RULE_01 eight channel register sets
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    // RULE_11 request line select
    assign trig[c] = irq_lines[ch_req[c][6:0]];
    dcr_chan u_chan (
      .hclk(hclk),
      .hresetn(hresetn),
      .reg_we((wr_chan && dsel_ch == 3'(c)) ? reg_we1h : 6'h00),
      .wdata(hwdata[15:0]),
      .trig(trig[c]),
      .step(step[c]),
      .ctrl_q(ch_ctrl[c]),
      .req_q(ch_req[c]),
      .sta_q(ch_sta[c]),
      .stb_q(ch_stb[c]),
      .pad_q(ch_pad[c]),
      .cnt_q(ch_cnt[c]),
      .ram_ptr(ch_ptr[c]),
      .busy(ch_busy[c]),
      .blk_evt(ch_evt[c])
    );
  end

  dcr_arb u_arb (
    .req(ch_busy),
    .gnt_valid(gv),
    .gnt_idx(gi)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rdv = 16'h0000;
    if (chan_hit) begin
      case (dsel_rg)
        RG_CTRL: begin
          rdv = ch_ctrl[dsel_ch];
        end
        RG_REQ: begin
          rdv = ch_req[dsel_ch];
        end
        RG_STA: begin
          rdv = ch_sta[dsel_ch];
        end
        RG_STB: begin
          rdv = ch_stb[dsel_ch];
        end
        RG_PAD: begin
          rdv = ch_pad[dsel_ch];
        end
        RG_CNT: begin
          rdv = ch_cnt[dsel_ch];
        end
        default: begin
          rdv = 16'h0000;
        end
      endcase
    end else if (stat_hit) begin
      rdv = s.status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n = s;
    set_p = 8'h00;
    set_x = 8'h00;
    ctl = ch_ctrl[gi];
    src = s.dir ? ram_rdata : per_rdata;
    bval = (s.dir ? s.ram_addr[0] : s.per_addr[0]) ? src[15:8] : src[7:0];
    // RULE_03 byte or word unit
    wd = s.byte_x ? {bval, bval} : src;

    // reads take one wait state so that hrdata comes from a flop
    if (s.dp_act && !s.dp_wr && !s.rdy) begin
      n.rdy = 1'b1;
      n.hrdata = {16'h0000, rdv};
    end else if (hready) begin
      n.dp_act = hsel && htrans[1];
      n.dp_wr = hwrite;
      n.dp_ok = (haddr[31:12] == 20'h0_0000);
      n.dp_word = (hsize == HSIZE_WORD);
      n.dp_addr = haddr[11:0];
      n.rdy = 1'b0;
    end

    case (s.fsm)
      ST_IDLE: begin
        if (gv) begin
          n.ch = gi;
          n.dir = ctl[B_DIR];
          n.byte_x = ctl[B_BYTE];
          n.null_periph_write = ctl[B_NULL_PERIPH_WRITE];
          // RULE_07 peripheral supplies part of the address
          n.ram_addr = ch_ptr[gi] + ((ctl[AM_HI:AM_LO] == AM_PIND) ? periph_index : 16'h0000);
          // RULE_14 peripheral address
          n.per_addr = ch_pad[gi];
          // RULE_04 source side read
          n.ram_rd = ctl[B_DIR];
          n.per_rd = !ctl[B_DIR];
          n.fsm = ST_READ;
        end
      end
      ST_READ: begin
        n.ram_rd = 1'b0;
        n.per_rd = 1'b0;
        n.fsm = ST_CAPT;
      end
      ST_CAPT: begin
        n.ram_be = s.byte_x ? (s.ram_addr[0] ? BE_HI : BE_LO) : BE_WORD;
        n.per_be = s.byte_x ? (s.per_addr[0] ? BE_HI : BE_LO) : BE_WORD;
        // RULE_04 destination side write
        if (s.dir) begin
          n.per_wr = 1'b1;
          n.per_wdata = wd;
        end else begin
          n.ram_wr = 1'b1;
          n.ram_wdata = wd;
          // RULE_06 extra null write
          if (s.null_periph_write) begin
            n.per_wr = 1'b1;
            n.per_wdata = 16'h0000;
          end
        end
        n.fsm = ST_WRITE;
      end
      ST_WRITE: begin
        // RULE_19 clash with a cpu write to the same address
        if (s.ram_wr && cpu_ram_wr && cpu_ram_addr == s.ram_addr) begin
          set_x[s.ch] = 1'b1;
        end
        if (s.per_wr && cpu_per_wr && cpu_per_addr == s.per_addr) begin
          set_p[s.ch] = 1'b1;
        end
        n.ram_wr = 1'b0;
        n.per_wr = 1'b0;
        n.fsm = ST_IDLE;
      end
      default: begin
        n.fsm = ST_IDLE;
      end
    endcase

    // RULE_17 writing zero clears a flag, a new clash in the same cycle wins
    if (wr_stat) begin
      n.status = s.status & hwdata[15:0];
    end
    n.status = n.status | {set_p, set_x};
    // RULE_05 block event per channel
    n.irq = ch_evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign hreadyout = !(s.dp_act && !s.dp_wr && !s.rdy);
  assign hrdata = s.hrdata;
  assign hresp = 1'b0;
  assign ram_addr = s.ram_addr;
  assign ram_wdata = s.ram_wdata;
  assign ram_rd = s.ram_rd;
  assign ram_wr = s.ram_wr;
  assign ram_be = s.ram_be;
  assign per_addr = s.per_addr;
  assign per_wdata = s.per_wdata;
  assign per_rd = s.per_rd;
  assign per_wr = s.per_wr;
  assign per_be = s.per_be;
  assign block_irq = s.irq;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_walk;
    s.fsm == ST_READ ##1 s.fsm == ST_CAPT ##1 s.fsm == ST_WRITE ##1 s.fsm == ST_IDLE;
  endsequence

  property p_walk;
    s.fsm == ST_IDLE && gv |=> s_walk;
  endproperty
  a_walk: assert property (p_walk) else $error("transfer walk broken"); // RULE_09

  property p_grant_on;
    s.fsm == ST_IDLE && gv |-> ch_ctrl[gi][B_ON];
  endproperty
  a_grant_on: assert property (p_grant_on) else $error("disabled channel served"); // RULE_02

  property p_byte_lane;
    s.fsm == ST_WRITE && s.byte_x && s.ram_wr |-> $onehot(s.ram_be);
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("byte lane wrong"); // RULE_03

  property p_dir;
    s.fsm == ST_WRITE && s.dir |-> s.per_wr && !s.ram_wr && $past(s.ram_rd, 2);
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong"); // RULE_04

  property p_null;
    s.fsm == ST_WRITE && !s.dir && s.null_periph_write |-> s.per_wr && s.ram_wr && s.per_wdata == 16'h0000;
  endproperty
  a_null: assert property (p_null) else $error("null write missing"); // RULE_06

  property p_xclash;
    s.fsm == ST_WRITE && s.ram_wr && cpu_ram_wr && cpu_ram_addr == s.ram_addr
      |=> s.status[$past(s.ch)];
  endproperty
  a_xclash: assert property (p_xclash) else $error("ram clash not flagged"); // RULE_19

  property p_cnt_zero;
    s.rdy && s.dp_act && !s.dp_wr && chan_hit && dsel_rg == RG_CNT |-> hrdata[31:10] == 22'h0;
  endproperty
  a_cnt_zero: assert property (p_cnt_zero) else $error("count upper bits not zero"); // RULE_18

  property p_rd_wait;
    hready && hsel && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong"); // bus read wait state

endmodule

// ---- dv/dcr_far_model.sv ----
`timescale 1ns/1ps
module dcr_far_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pulse_req,
  input wire logic [6:0] pulse_num,
  output logic [127:0] irq_lines,
  input wire logic [15:0] ram_addr,
  input wire logic ram_rd,
  output logic [15:0] ram_rdata,
  input wire logic [15:0] per_addr,
  input wire logic per_rd,
  output logic [15:0] per_rdata
);
  // read data is valid one cycle only; it toggles after, so a late sample is caught
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_lines <= '0;
      ram_rdata <= 16'h0000;
      per_rdata <= 16'h0000;
    end else begin
      irq_lines <= pulse_req ? (128'h1 << pulse_num) : '0;
      ram_rdata <= ram_rd ? (ram_addr ^ 16'h5a5a) : ~ram_rdata;
      per_rdata <= per_rd ? (per_addr ^ 16'hc3c3) : ~per_rdata;
    end
  end
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench import dcr_pkg::*;;
  typedef struct {logic [31:0] a; logic [15:0] w; logic [15:0] e;} dcr_row_type;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pulse_req;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, ram_be, per_be;
  logic [2:0] hsize;
  logic [127:0] irq_lines;
  logic [15:0] periph_index, ram_addr, ram_wdata, ram_rdata, per_addr, per_wdata, per_rdata;
  logic [15:0] cpu_ram_addr, cpu_per_addr;
  logic ram_rd, ram_wr, per_rd, per_wr, cpu_ram_wr, cpu_per_wr;
  logic [6:0] pulse_num;
  logic [7:0] block_irq;
  logic [33:0] ram_q[$];
  logic [33:0] per_q[$];
  int blk[8];
  int n_mismatch;
  int checks;
  dcr_row_type rows[9] = '{
    '{32'h0000_0000, 16'hffff, 16'hf833}, '{32'h0000_0000, 16'h0000, 16'h0000},
    '{32'h0000_0024, 16'h7fff, 16'h007f}, '{32'h0000_0048, 16'hffff, 16'hffff},
    '{32'h0000_006c, 16'h1234, 16'h1234}, '{32'h0000_0090, 16'habcd, 16'habcd},
    '{32'h0000_00f4, 16'hffff, 16'h03ff}, '{32'h0000_00fc, 16'hffff, 16'h0000},
    '{32'h0000_0100, 16'hffff, 16'h0000}};

  dcr_dma dcr_dma_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq_lines(irq_lines),
    .periph_index(periph_index), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_be(ram_be), .ram_rdata(ram_rdata),
    .per_addr(per_addr), .per_wdata(per_wdata), .per_rd(per_rd), .per_wr(per_wr),
    .per_be(per_be), .per_rdata(per_rdata), .cpu_ram_wr(cpu_ram_wr),
    .cpu_ram_addr(cpu_ram_addr), .cpu_per_wr(cpu_per_wr), .cpu_per_addr(cpu_per_addr),
    .block_irq(block_irq));
  dcr_far_model dcr_far_model_i (.hclk(hclk), .hresetn(hresetn), .pulse_req(pulse_req),
    .pulse_num(pulse_num), .irq_lines(irq_lines), .ram_addr(ram_addr), .ram_rd(ram_rd),
    .ram_rdata(ram_rdata), .per_addr(per_addr), .per_rd(per_rd), .per_rdata(per_rdata));

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk) begin
    if (ram_wr === 1'b1) ram_q.push_back({ram_be, ram_addr, ram_wdata});
    if (per_wr === 1'b1) per_q.push_back({per_be, per_addr, per_wdata});
    for (int i = 0; i < NUM_CH; i++) blk[i] += (block_irq[i] === 1'b1) ? 1 : 0;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic timeout(input string m);
    n_mismatch++;
    $display("mismatch at %0t: no answer for %s", $time, m);
    give_verdict();
  endtask

  task automatic wait_ready;
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 50) timeout("bus");
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    wait_ready();
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [15:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk({2'b00, q}, {18'h0_0000, e}, "register read");
    chk({33'h0_0000_0000, hresp}, 34'h0_0000_0000, "bus response");
  endtask

  function automatic logic [31:0] ra(input int c, input logic [2:0] r);
    return (32'(c) << CH_LSB) | (32'(r) << 2);
  endfunction

  // channel setup; address and count only written while the channel is off
  // software order
  task automatic setup(input int c, input logic [15:0] primary_start_addr, input logic [15:0] pad,
                       input logic [15:0] cnt, input logic [15:0] req);
    wr(ra(c, RG_STA), primary_start_addr);
    wr(ra(c, RG_PAD), pad);
    wr(ra(c, RG_CNT), cnt);
    wr(ra(c, RG_REQ), req);
  endtask

  task automatic pulse(input logic [6:0] n);
    @(posedge hclk);
    pulse_req <= 1'b1;
    pulse_num <= n;
    @(posedge hclk);
    pulse_req <= 1'b0;
  endtask

  task automatic exp_wr(input logic per, input logic [33:0] e);
    int i;
    // look between edges so the monitor has already queued the write
    for (i = 0; i < 40; i++) begin
      @(negedge hclk);
      if ((per ? per_q.size() : ram_q.size()) > 0) break;
    end
    if (i == 40) timeout("transfer");
    chk(per ? per_q.pop_front() : ram_q.pop_front(), e, "bus write");
  endtask

  task automatic quiet;
    repeat (12) @(posedge hclk);
    chk(34'(ram_q.size() + per_q.size()), 34'd0, "unexpected transfer");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  initial begin
    {hsel, hwrite, pulse_req, cpu_ram_wr, cpu_per_wr} = '0;
    {haddr, hwdata, htrans, hsize, pulse_num} = '0;
    {periph_index, cpu_ram_addr, cpu_per_addr} = '0;
    hresetn = 1'b0;
    n_mismatch = 0;
    checks = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (int c = 0; c < NUM_CH; c++)
      for (int r = 0; r < 6; r++) rd_chk(ra(c, 3'(r)), REG_RESET);
    rd_chk(32'(STATUS_ADDR), REG_RESET);
    $display("test reset values done");
    for (int k = 0; k < 9; k++) begin
      wr(rows[k].a, rows[k].w);
      rd_chk(rows[k].a, rows[k].e);
    end
    $display("test register table done");
    // force held off while disabled, survives a zero write
    setup(0, 16'h0040, 16'h0300, 16'h0001, 16'h8005);
    quiet();
    wr(ra(0, RG_REQ), 16'h0005);
    rd_chk(ra(0, RG_REQ), 16'h8005);
    wr(ra(0, RG_CTRL), 16'h8001);
    exp_wr(1'b0, {BE_WORD, 16'h0040, 16'hc0c3});
    rd_chk(ra(0, RG_REQ), 16'h0005);
    pulse(7'd5);
    exp_wr(1'b0, {BE_WORD, 16'h0042, 16'hc0c3});
    // the block event follows the write cycle and is counted one edge later
    repeat (2) @(negedge hclk);
    chk(34'(blk[0]), 34'd1, "block event");
    rd_chk(ra(0, RG_CTRL), 16'h0001);
    pulse(7'd5);
    quiet();
    $display("test force and one-shot done");
    setup(1, 16'h0011, 16'h0200, 16'h0000, 16'h8000);
    wr(ra(1, RG_CTRL), 16'he001);
    exp_wr(1'b1, {BE_LO, 16'h0200, 16'h5a5a});
    $display("test byte to peripheral done");
    cpu_ram_wr <= 1'b1;
    cpu_ram_addr <= 16'h0080;
    cpu_per_wr <= 1'b1;
    cpu_per_addr <= 16'h0310;
    setup(2, 16'h0080, 16'h0310, 16'h0000, 16'h0000);
    wr(ra(2, RG_CTRL), 16'h8801);
    wr(ra(2, RG_REQ), 16'h8000);
    exp_wr(1'b0, {BE_WORD, 16'h0080, 16'hc0d3});
    exp_wr(1'b1, {BE_WORD, 16'h0310, 16'h0000});
    cpu_ram_wr <= 1'b0;
    cpu_per_wr <= 1'b0;
    rd_chk(32'(STATUS_ADDR), 16'h0404);
    wr(32'(STATUS_ADDR), 16'h0000);
    rd_chk(32'(STATUS_ADDR), 16'h0000);
    $display("test null write and clash done");
    wr(ra(3, RG_STB), 16'h0200);
    setup(3, 16'h0100, 16'h0320, 16'h0000, 16'h0009);
    wr(ra(6, RG_REQ), 16'h0009);
    wr(ra(3, RG_CTRL), 16'h8002);
    for (int k = 0; k < 3; k++) begin
      pulse(7'd9);
      exp_wr(1'b0, {BE_WORD, (k == 1) ? 16'h0200 : 16'h0100, 16'hc0e3});
    end
    quiet();
    chk(34'(blk[3]), 34'd3, "ping-pong events");
    chk(34'(blk[6]), 34'd0, "disabled channel event");
    wr(ra(3, RG_CTRL), 16'h0000);
    wr(ra(3, RG_CTRL), 16'h8003);
    for (int k = 0; k < 2; k++) begin
      pulse(7'd9);
      exp_wr(1'b0, {BE_WORD, (k == 1) ? 16'h0200 : 16'h0100, 16'hc0e3});
    end
    rd_chk(ra(3, RG_CTRL), 16'h0003);
    $display("test ping-pong done");
    setup(4, 16'h0500, 16'h0330, 16'h0003, 16'h000a);
    wr(ra(4, RG_CTRL), 16'h9011);
    for (int k = 0; k < 4; k++) begin
      pulse(7'd10);
      exp_wr(1'b0, {BE_WORD, 16'h0500, 16'hc0f3});
    end
    repeat (3) @(posedge hclk);
    chk(34'(blk[4]), 34'd1, "half block event");
    rd_chk(ra(4, RG_CTRL), 16'h1011);
    $display("test half and fixed address done");
    periph_index <= 16'h0006;
    setup(5, 16'h0600, 16'h0340, 16'h0000, 16'h0000);
    wr(ra(5, RG_CTRL), 16'h8020);
    wr(ra(5, RG_REQ), 16'h8000);
    exp_wr(1'b0, {BE_WORD, 16'h0606, 16'hc083});
    rd_chk(ra(5, RG_CTRL), 16'h8020);
    $display("test peripheral indirect done");
    give_verdict();
  end
endmodule
